// >>> wdt_lock_seq.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_lock_seq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr,
   input wire logic [2:0] wdata,
   output logic lock_low,
   output logic lock_ie,
   output wdt_pkg::lock_bits_s readback
);

   wdt_pkg::lock_state_e state;
   logic [2:0] win_left;

   // ------------------------------------------------------------
   // two-write timed lock sequence
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= wdt_pkg::LOCK_OPEN;
         win_left <= 3'h0;
      end else begin
         case (state)
            wdt_pkg::LOCK_OPEN: begin
               if (wr && wdata == wdt_pkg::LOCK_ARM_CODE) begin
                  state <= wdt_pkg::LOCK_ARMED;
                  win_left <= wdt_pkg::LOCK_WINDOW_CYCLES;
               end
            end
            wdt_pkg::LOCK_ARMED: begin
               if (wr && wdata == wdt_pkg::LOCK_FULL_CODE) begin
                  state <= wdt_pkg::LOCK_FULL; // [RULE6]
               end else if (wr && wdata == wdt_pkg::LOCK_PARTIAL_CODE) begin
                  state <= wdt_pkg::LOCK_PARTIAL; // [RULE7]
               end else if (wr && wdata == wdt_pkg::LOCK_ARM_CODE) begin
                  win_left <= wdt_pkg::LOCK_WINDOW_CYCLES;
               end else if (wr || win_left == 3'h1) begin
                  state <= wdt_pkg::LOCK_OPEN; // [RULE12]
               end else begin
                  win_left <= win_left - 3'h1;
               end
            end
            // locked states leave only through hardware reset
            wdt_pkg::LOCK_FULL: state <= wdt_pkg::LOCK_FULL; // [RULE4]
            wdt_pkg::LOCK_PARTIAL: state <= wdt_pkg::LOCK_PARTIAL; // [RULE4]
            default: state <= wdt_pkg::LOCK_OPEN;
         endcase
      end
   end

   assign lock_low = (state == wdt_pkg::LOCK_FULL) || (state == wdt_pkg::LOCK_PARTIAL);
   assign lock_ie = (state == wdt_pkg::LOCK_FULL);
   assign readback = (state == wdt_pkg::LOCK_ARMED) ? wdt_pkg::LOCK_ARM_CODE :
                     (state == wdt_pkg::LOCK_FULL) ? wdt_pkg::LOCK_FULL_CODE :
                     (state == wdt_pkg::LOCK_PARTIAL) ? wdt_pkg::LOCK_PARTIAL_CODE :
                     wdt_pkg::LOCK_NONE_CODE;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_LOCK_STICKY: assert property (lock_low |=> lock_low && $stable(lock_ie)) // [RULE4]
      else $error("lock level changed after entry");
   AST_FULL_ENTRY: assert property ( // [RULE6]
      state == wdt_pkg::LOCK_ARMED && wr && wdata == wdt_pkg::LOCK_FULL_CODE |=> lock_ie ##1 lock_ie)
      else $error("full lock not entered");
   AST_PARTIAL_ENTRY: assert property ( // [RULE7]
      state == wdt_pkg::LOCK_ARMED && wr && wdata == wdt_pkg::LOCK_PARTIAL_CODE |=> lock_low && !lock_ie)
      else $error("partial lock not entered");
   AST_WINDOW_EXPIRE: assert property ( // [RULE12]
      (state == wdt_pkg::LOCK_ARMED && !wr) [*4] |=> state == wdt_pkg::LOCK_OPEN && !lock_low)
      else $error("armed state outlived its window");
   COV_FULL: cover property (state == wdt_pkg::LOCK_ARMED ##1 state == wdt_pkg::LOCK_FULL);
   COV_PARTIAL: cover property (state == wdt_pkg::LOCK_ARMED ##1 state == wdt_pkg::LOCK_PARTIAL);

endmodule
`default_nettype wire

// >>> wdt_osc_counter.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_osc_counter #(
   parameter int BASE_OSC_CYCLES = wdt_pkg::BASE_OSC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_pin,
   input wire logic run,
   input wire logic kick,
   input wire logic [3:0] period,
   output logic timeout
);

   localparam logic [20:0] BASE21 = 21'(BASE_OSC_CYCLES);

   logic [2:0] sync;
   logic osc_level;
   logic [20:0] count;
   wire tick;
   wire [20:0] limit;

   // ------------------------------------------------------------
   // oscillator edge detection, counted in pclk domain
   // ------------------------------------------------------------
   assign tick = (sync[1] == sync[2]) && sync[2] && !osc_level; // [RULE2]
   // reserved codes fall back to the longest period, the safe side
   assign limit = ((period > wdt_pkg::PERIOD_MAX_CODE) ? (BASE21 << wdt_pkg::PERIOD_MAX_CODE)
                                                        : (BASE21 << period)) - 21'h1; // [RULE1]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync <= 3'h0;
         osc_level <= 1'b0;
      end else begin
         sync <= {sync[1], sync[0], osc_pin};
         osc_level <= (sync[1] == sync[2]) ? sync[2] : osc_level;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 21'h0;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (!run || kick) begin
            count <= 21'h0;
         end else if (tick) begin
            if (count >= limit) begin
               count <= 21'h0;
               timeout <= 1'b1; // [RULE1]
            end else begin
               count <= count + 21'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_TIMEOUT_AT_LIMIT: assert property (timeout |-> $past(count) >= $past(limit) && count == 21'h0) // [RULE1]
      else $error("time-out before the selected count");
   AST_TIMEOUT_ON_TICK: assert property (timeout |-> $past(tick) && $past(run)) // [RULE2]
      else $error("time-out without an oscillator edge");
   COV_TIMEOUT: cover property (run ##1 timeout);

endmodule
`default_nettype wire

// >>> wdt_period_lock.sv
// Contract
// RULE1: period code sets 2K..1024K oscillator cycles time-out
// RULE2: time-out counts low-power oscillator edges
// RULE3: lock register bits 7:3 read zero
// RULE4: lock holds until hardware reset
// RULE5: software arms with arm and both levels
// RULE6: arm-clear plus upper level locks bits 6:0
// RULE7: lower level alone locks bits 5:0
// RULE8: software configures early, then locks
// RULE9: partial lock for interrupt re-arm use
// RULE10: change enable gates period, self-clears after four
// RULE11: bit 6 is interrupt enable, partial-writable
// RULE12: missed window discards arming, no lock
`timescale 1ns/1ns
`default_nettype none
module wdt_period_lock #(
   parameter int BASE_OSC_CYCLES = wdt_pkg::BASE_OSC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic ulp_osc,
   input wire logic wdt_kick,
   input wire logic irq_ack,
   output logic wdt_irq,
   output logic wdt_system_reset
);

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wdt_pkg::ctrl_s ctrl;
   wdt_pkg::ctrl_s next_ctrl;
   logic [2:0] ce_cnt;
   logic [2:0] next_ce_cnt;
   wdt_pkg::lock_bits_s lock_rd;
   logic lock_low;
   logic lock_ie;
   logic timeout;

   wire access = psel && penable;
   wire done = access && pready;
   wire hit_ctrl = (paddr == wdt_pkg::CTRL_OFFSET);
   wire hit_lock = (paddr == wdt_pkg::LOCK_OFFSET);
   wire hit_any = hit_ctrl || hit_lock;
   wire wr_ctrl = done && pwrite && hit_ctrl;
   wire wr_lock = done && pwrite && hit_lock;

   // write data fields
   wire w_flag = pwdata[wdt_pkg::CTRL_IRQ_FLAG_BIT];
   wire w_ie = pwdata[wdt_pkg::CTRL_IRQ_EN_BIT];
   wire w_ce = pwdata[wdt_pkg::CTRL_CHANGE_EN_BIT];
   wire w_re = pwdata[wdt_pkg::CTRL_RESET_EN_BIT];
   wire [3:0] w_period = {pwdata[wdt_pkg::CTRL_PERIOD_HI_BIT], pwdata[wdt_pkg::CTRL_PERIOD_LO_MSB:0]};
   wire [2:0] w_lock = pwdata[wdt_pkg::LOCK_FIELD_MSB:0]; // [RULE3]

   // read data
   wire [7:0] ctrl_byte = {ctrl.irq_flag, ctrl.irq_en, ctrl.period[3], ctrl.change_en,
                           ctrl.reset_en, ctrl.period[2:0]};
   wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_byte} :
                        hit_lock ? {29'h0, lock_rd} : 32'h0; // [RULE3]

   // ------------------------------------------------------------
   // lock sequencer and period counter
   // ------------------------------------------------------------
   wdt_lock_seq u_lock (
      .pclk(pclk),
      .presetn(presetn),
      .wr(wr_lock),
      .wdata(w_lock),
      .lock_low(lock_low),
      .lock_ie(lock_ie),
      .readback(lock_rd)
   );

   wdt_osc_counter #(
      .BASE_OSC_CYCLES(BASE_OSC_CYCLES)
   ) u_count (
      .pclk(pclk),
      .presetn(presetn),
      .osc_pin(ulp_osc),
      .run(ctrl.reset_en || ctrl.irq_en),
      .kick(wdt_kick),
      .period(ctrl.period),
      .timeout(timeout)
   );

   // ------------------------------------------------------------
   // watchdog control register
   // ------------------------------------------------------------
   wire ce_active = ctrl.change_en;
   wire flag_set = timeout && ctrl.irq_en;
   wire flag_clr = (wr_ctrl && w_flag) || irq_ack;
   // interrupt-and-reset mode falls to reset when the previous interrupt went unserved
   wire reset_req = timeout && ctrl.reset_en && (!ctrl.irq_en || ctrl.irq_flag);

   always_comb begin
      next_ctrl = ctrl;
      next_ce_cnt = ce_cnt;
      if (irq_ack && ctrl.reset_en) begin
         next_ctrl.irq_en = 1'b0;
      end
      if (wr_ctrl && !lock_ie) begin
         next_ctrl.irq_en = w_ie; // [RULE11] [RULE4]
      end
      // self-clearing change enable window
      if (ctrl.change_en) begin
         if (ce_cnt == 3'h0) begin
            next_ctrl.change_en = 1'b0; // [RULE10]
         end else begin
            next_ce_cnt = ce_cnt - 3'h1;
         end
      end
      if (wr_ctrl && !lock_low) begin // [RULE4]
         if (ce_active) begin
            next_ctrl.period = w_period; // [RULE10] [RULE1]
         end
         if (w_re) begin
            next_ctrl.reset_en = 1'b1;
         end else if (ce_active) begin
            next_ctrl.reset_en = 1'b0; // [RULE10]
         end
         if (w_ce) begin
            next_ctrl.change_en = 1'b1;
            next_ce_cnt = wdt_pkg::CHANGE_ENABLE_CYCLES - 3'h1;
         end
      end
      // a time-out in the clearing cycle still sets the flag
      if (flag_set) begin
         next_ctrl.irq_flag = 1'b1;
      end else if (flag_clr) begin
         next_ctrl.irq_flag = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= wdt_pkg::CTRL_RESET;
         ce_cnt <= 3'h0;
      end else begin
         ctrl <= next_ctrl;
         ce_cnt <= next_ce_cnt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_irq <= 1'b0;
         wdt_system_reset <= 1'b0;
      end else begin
         wdt_irq <= next_ctrl.irq_flag && next_ctrl.irq_en;
         wdt_system_reset <= reset_req;
      end
   end

   // ------------------------------------------------------------
   // apb slave: one wait state, answer registered
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= access && !pready;
         if (access && !pready) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
            pslverr <= !hit_any;
         end else begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_RESERVED_ZERO: assert property (done && !pwrite && hit_lock |-> prdata[31:3] == 29'h0) // [RULE3]
      else $error("lock register upper bits not zero");
   AST_LOCKED_FROZEN: assert property ( // [RULE4]
      lock_low && wr_ctrl |=> ctrl.period == $past(ctrl.period) && ctrl.reset_en == $past(ctrl.reset_en))
      else $error("locked control bits changed");
   AST_IE_FULL_FROZEN: assert property (lock_ie && wr_ctrl && !irq_ack |=> $stable(ctrl.irq_en)) // [RULE6]
      else $error("interrupt enable changed under full lock");
   AST_IE_PARTIAL_OPEN: assert property ( // [RULE11]
      lock_low && !lock_ie && wr_ctrl && !irq_ack |=> ctrl.irq_en == $past(w_ie))
      else $error("interrupt enable not writable under partial lock");
   AST_PERIOD_NEEDS_CE: assert property (wr_ctrl && !ctrl.change_en |=> $stable(ctrl.period)) // [RULE10]
      else $error("period changed without change enable");
   AST_CE_AUTOCLEAR: assert property ( // [RULE10]
      wr_ctrl && !lock_low && w_ce |=> ctrl.change_en [*4] ##1
      (!ctrl.change_en || $past(wr_ctrl) || $past(wr_ctrl, 2)))
      else $error("change enable did not clear after four cycles");
   AST_RESET_MODE: assert property (timeout && ctrl.reset_en && !ctrl.irq_en |=> wdt_system_reset) // [RULE1]
      else $error("reset mode time-out gave no reset");
   AST_FLAG_SET_WINS: assert property (timeout && ctrl.irq_en |=> ctrl.irq_flag)
      else $error("time-out flag lost");
   AST_READY_WAIT: assert property (access && !pready |=> pready)
      else $error("no answer after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error outside a transfer");
   AST_ERR_DECODE: assert property (done |-> pslverr == !hit_any)
      else $error("error response does not match decode");
   AST_PERIOD_TAKEN: assert property ( // [RULE10]
      wr_ctrl && !lock_low && ctrl.change_en |=> ctrl.period == $past(w_period))
      else $error("period write lost under change enable");
   AST_ACK_DROPS_IE: assert property (irq_ack && ctrl.reset_en && !wr_ctrl |=> !ctrl.irq_en)
      else $error("vector taken left interrupt enable set");
   AST_RESET_PULSE: assert property (wdt_system_reset |=> !wdt_system_reset)
      else $error("system reset request longer than one cycle");
   COV_RESET: cover property (wdt_system_reset);
   COV_IRQ: cover property (lock_low && !lock_ie ##1 wdt_irq);

endmodule
`default_nettype wire

// >>> wdt_period_lock_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_period_lock_tb;
   localparam int BASE = 4;
   localparam logic [11:0] CTRL = wdt_pkg::CTRL_OFFSET;
   localparam logic [11:0] LOCK = wdt_pkg::LOCK_OFFSET;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic ulp_osc, wdt_kick, irq_ack, wdt_irq, wdt_system_reset, osc_run, er_v;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [3:0] code;
   int n_mismatch, checks_done, cyc, n_osc, ctrl_m, lock_st, arm_cyc, ce_cyc;

   wdt_period_lock #(.BASE_OSC_CYCLES(BASE)) wdt_period_lock_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ulp_osc(ulp_osc), .wdt_kick(wdt_kick), .irq_ack(irq_ack), .wdt_irq(wdt_irq),
      .wdt_system_reset(wdt_system_reset));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk) cyc <= cyc + 1;

   // oscillator pin: 4 pclk per level, above the 3-flop sync minimum
   initial begin
      forever begin
         repeat (4) @(posedge pclk);
         if (osc_run === 1'b1) begin
            if (ulp_osc == 1'b0) n_osc++;
            ulp_osc <= ~ulp_osc;
         end
      end
   end

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [31:0] exp_rd(input logic [11:0] a);
      if (a == CTRL) return 32'(ctrl_m & 'hFF);
      if (a == LOCK) return (lock_st == 2) ? 32'h4 : (lock_st == 3) ? 32'h2 : 32'h0;
      return 32'h0;
   endfunction

   task automatic m_wr(input logic [11:0] a, input int v, input int c);
      int msk, nv;
      bit ce;
      if (a == CTRL) begin
         msk = (lock_st == 2) ? 'h80 : (lock_st == 3) ? 'hC0 : 'hFF;
         ce = (c - ce_cyc) <= 3;
         nv = ctrl_m;
         if (v & 'h80) nv = nv & ~'h80;
         nv = (nv & ~'h40) | (v & 'h40);
         if (ce) nv = (nv & ~'h27) | (v & 'h27);
         if (v & 'h08) nv = nv | 'h08;
         else if (ce) nv = nv & ~'h08;
         ctrl_m = (ctrl_m & ~msk) | (nv & msk);
         if ((msk & 'h10) && (v & 'h10)) ce_cyc = c;
      end else if (a == LOCK && lock_st < 2) begin
         if (lock_st == 1 && c - arm_cyc > 4) lock_st = 0;
         if ((v & 7) == 7) begin
            lock_st = 1;
            arm_cyc = c;
         end else if (lock_st == 1 && (v & 7) == 4) lock_st = 2;
         else if (lock_st == 1 && (v & 7) == 2) lock_st = 3;
         else lock_st = 0;
      end
   endtask

   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // leaves the request up so a setup can follow at once
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd,
                      output logic er);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         n_mismatch++;
         tally_and_finish();
      end else begin
         rd = prdata;
         er = pslverr;
         if (wr) m_wr(a, int'(d), cyc);
      end
   endtask

   task automatic idle(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, rd_v, er_v);
      idle(1);
   endtask

   task automatic wr2(input logic [11:0] a, input logic [7:0] d1, input logic [7:0] d2);
      apb(1'b1, a, d1, rd_v, er_v);
      apb(1'b1, a, d2, rd_v, er_v);
      idle(1);
   endtask

   // waits first so that any change enable has lapsed
   task automatic rdc(input logic [11:0] a);
      repeat (4) @(posedge pclk);
      apb(1'b0, a, 8'h00, rd_v, er_v);
      idle(1);
      chk(rd_v, exp_rd(a));
      chk({31'h0, er_v}, {31'h0, (a != CTRL && a != LOCK)});
   endtask

   task automatic rst();
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ctrl_m = 0;
      lock_st = 0;
      arm_cyc = -100;
      ce_cyc = -100;
   endtask

   task automatic run_to(input bit irq, input int exp);
      int k;
      n_osc = 0;
      wdt_kick <= 1'b0;
      osc_run <= 1'b1;
      k = 0;
      while ((irq ? wdt_irq : wdt_system_reset) !== 1'b1 && k < 40000) begin
         @(posedge pclk);
         k++;
      end
      osc_run <= 1'b0;
      if (k >= 40000) begin
         n_mismatch++;
         tally_and_finish();
      end else chk(n_osc, exp);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, ulp_osc, wdt_kick, irq_ack, osc_run, paddr, pwdata} = 52'h0;
      {n_mismatch, checks_done, cyc, n_osc} = {4{32'sd0}};
      void'($urandom(32'h00AE21C6));
      rst();
      rdc(CTRL);
      rdc(LOCK);
      wr(12'h068, 8'hFF);
      rdc(12'h068);
      wr(LOCK, 8'hF8);
      rdc(LOCK);
      $display("test reset_and_map done");
      wr(CTRL, 8'h25);
      rdc(CTRL);
      code = 4'($urandom_range(1, 9));
      wr2(CTRL, 8'h18, {2'b00, code[3], 2'b01, code[2:0]});
      rdc(CTRL);
      wr(CTRL, 8'h18);
      idle(4);
      wr(CTRL, 8'h00);
      rdc(CTRL);
      wr2(CTRL, 8'h18, 8'h00);
      rdc(CTRL);
      $display("test change_enable done");
      for (int i = 0; i < 2; i++) begin
         code = (i == 0) ? 4'($urandom_range(0, 3)) : 4'($urandom_range(10, 15));
         rst();
         wdt_kick <= 1'b1;
         wr2(CTRL, 8'h18, {2'b00, code[3], 2'b01, code[2:0]});
         run_to(1'b0, BASE << ((code > 9) ? 9 : code));
      end
      rst();
      wdt_kick <= 1'b1;
      wr(CTRL, 8'h40);
      run_to(1'b1, BASE);
      ctrl_m = ctrl_m | 'h80;
      rdc(CTRL);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge pclk);
      ctrl_m = ctrl_m & ~'h80;
      chk({31'h0, wdt_irq}, 32'h0);
      rdc(CTRL);
      wr(CTRL, 8'h48);
      run_to(1'b1, BASE);
      idle(1);
      run_to(1'b0, BASE);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      ctrl_m = ctrl_m & ~'hC0;
      rdc(CTRL);
      $display("test timeout done");
      rst();
      wr(CTRL, 8'h48);
      wr2(LOCK, 8'h07, 8'h02);
      rdc(LOCK);
      wr(CTRL, 8'h18);
      rdc(CTRL);
      wr(CTRL, 8'h40);
      rdc(CTRL);
      wr2(LOCK, 8'h07, 8'h04);
      rdc(LOCK);
      rst();
      wr2(LOCK, 8'hFF, 8'hFC);
      rdc(LOCK);
      wr(CTRL, 8'h48);
      rdc(CTRL);
      rst();
      rdc(LOCK);
      wr(CTRL, 8'h48);
      rdc(CTRL);
      wr(LOCK, 8'h07);
      idle(4);
      wr(LOCK, 8'h04);
      rdc(LOCK);
      wr(CTRL, 8'h08);
      rdc(CTRL);
      $display("test lock done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// >>> wdt_pkg.sv
`default_nettype none
package wdt_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET = 12'h060;
   localparam logic [11:0] LOCK_OFFSET = 12'h064;

   // ------------------------------------------------------------
   // control register field positions
   // ------------------------------------------------------------
   localparam int CTRL_IRQ_FLAG_BIT = 7;
   localparam int CTRL_IRQ_EN_BIT = 6;
   localparam int CTRL_PERIOD_HI_BIT = 5;
   localparam int CTRL_CHANGE_EN_BIT = 4;
   localparam int CTRL_RESET_EN_BIT = 3;
   localparam int CTRL_PERIOD_LO_MSB = 2;
   localparam int LOCK_FIELD_MSB = 2;

   // ------------------------------------------------------------
   // reset values and lock codes {upper, lower, arm}
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] LOCK_RESET = 8'h00;
   localparam logic [2:0] LOCK_ARM_CODE = 3'h7;
   localparam logic [2:0] LOCK_FULL_CODE = 3'h4;
   localparam logic [2:0] LOCK_PARTIAL_CODE = 3'h2;
   localparam logic [2:0] LOCK_NONE_CODE = 3'h0;

   // ------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------
   localparam logic [2:0] LOCK_WINDOW_CYCLES = 3'h4;
   localparam logic [2:0] CHANGE_ENABLE_CYCLES = 3'h4;
   localparam int BASE_OSC_CYCLES = 2048;
   localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
   localparam int OSC_COUNT_WIDTH = 21;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic irq_flag;
      logic irq_en;
      logic reset_en;
      logic change_en;
      logic [3:0] period;
   } ctrl_s;

   typedef struct packed {
      logic upper;
      logic lower;
      logic arm;
   } lock_bits_s;

   typedef enum {LOCK_OPEN, LOCK_ARMED, LOCK_FULL, LOCK_PARTIAL} lock_state_e;

endpackage
`default_nettype wire
